// File: design/interval_timer.sv
// Top of the 16-bit interval timer with an Avalon-MM register port.
// Assumes the external count and gate pins are asynchronous to clk.
// Assumes cpu_idle comes from logic on clk, so it needs no synchroniser.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module interval_timer
  import interval_timer_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave.
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Pins and processor state.
  input wire logic ext_count_input,
  input wire logic ext_gate_input,
  input wire logic cpu_idle,
  // Interrupt request and its priority.
  output logic tick_irq,
  output logic [2:0] tick_irq_priority
);

  tick_control_s ctl_reg, ctl_next;
  logic [15:0] count_reg, count_next;
  logic [15:0] period_value_reg, period_value_next;
  logic flag_reg, flag_next;
  logic ien_reg, ien_next;
  logic [2:0] prio_reg, prio_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic wait_reg, wait_next;
  logic irq_reg, irq_next;
  logic [1:0] ck_sync_reg, gt_sync_reg;
  logic [1:0] ck_sync_next;
  logic [1:0] gt_sync_next;
  logic ck_last_reg, gt_last_reg, raw_last_reg;
  logic ck_last_next;
  logic gt_last_next;
  logic raw_last_next;
  logic raw_in; // Count pin after the chosen number of stages.
  logic raw_edge; // One-cycle pulse on a count pin rising edge.
  logic raw_tick; // Undivided count tick.
  logic div_tick; // Count tick after the prescaler.
  logic running; // Run bit qualified by stop-in-idle.
  logic gate_fall; // Gate falling edge in gated internal mode.
  logic match_reg, match_next;

  // Next values of the pin synchronisers and of the edge-history flops.
  always_comb begin
    ck_sync_next = {ck_sync_reg[0], ext_count_input};
    gt_sync_next = {gt_sync_reg[0], ext_gate_input};
    ck_last_next = ck_sync_reg[1];
    gt_last_next = gt_sync_reg[1];
    raw_last_next = raw_in;
  end

  // Two-flop synchronisers for both pins; only the second stage feeds logic.
  // History flops reset to the resting low level, so no false edge follows reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ck_sync_reg <= 2'h0;
      gt_sync_reg <= 2'h0;
      ck_last_reg <= 1'b0;
      gt_last_reg <= 1'b0;
      raw_last_reg <= 1'b0;
    end else begin
      ck_sync_reg <= ck_sync_next;
      gt_sync_reg <= gt_sync_next;
      ck_last_reg <= ck_last_next;
      gt_last_reg <= gt_last_next;
      raw_last_reg <= raw_last_next;
    end
  end

  // Unsynchronised mode skips the extra edge-align stage; both are on clk.
  assign raw_in = ctl_reg.ext_clock_resync ? ck_last_reg : ck_sync_reg[1];
  assign raw_edge = raw_in & ~raw_last_reg;
  // Run gating and stop-in-idle.
  assign running = ctl_reg.timer_run & ~(cpu_idle & ctl_reg.idle_stop);

  // Select the raw tick source.
  always_comb begin
    raw_tick = 1'b0;
    if (running) begin
      if (ctl_reg.count_source_select) begin
        raw_tick = raw_edge;
      end else if (ctl_reg.gated_accumulate) begin
        raw_tick = gt_sync_reg[1];
      end else begin
        raw_tick = 1'b1;
      end
    end
  end

  // Gate falling edge counts only in gated internal mode.
  assign gate_fall = ctl_reg.timer_run & ~ctl_reg.count_source_select &
                     ctl_reg.gated_accumulate & gt_last_reg & ~gt_sync_reg[1];

  // The prescaler is cleared while the run bit is zero, so every run-bit start begins a full ratio.
  tick_prescaler u_pre (
    .clk(clk),
    .rst_n(rst_n),
    .clear(~ctl_reg.timer_run),
    .divide_sel(ctl_reg.clock_divide_select),
    .raw_tick(raw_tick),
    .div_tick(div_tick)
  );

  // Counter, control, period and interrupt registers.
  // A count write lands after any tick of the same cycle, so software sees
  // exactly the value it wrote.
  always_comb begin
    ctl_next = ctl_reg;
    count_next = count_reg;
    period_value_next = period_value_reg;
    flag_next = flag_reg;
    ien_next = ien_reg;
    prio_next = prio_reg;
    match_next = 1'b0;
    // Count tick: wrap on match, else increment.
    if (div_tick) begin
      if (count_reg == period_value_reg) begin
        count_next = 16'h0000;
        match_next = 1'b1;
      end else begin
        count_next = count_reg + 16'h0001;
      end
    end
    // Register writes take effect on the edge that ends the wait cycle, one edge before acceptance.
    if (write & ~ack_reg) begin
      case (address)
        ctrl_off: begin
          ctl_next.timer_run = writedata[run_bit];
          ctl_next.idle_stop = writedata[idle_stop_bit];
          ctl_next.gated_accumulate = writedata[gate_bit];
          ctl_next.clock_divide_select = writedata[div_lo_bit +: 2];
          ctl_next.ext_clock_resync = writedata[resync_bit];
          ctl_next.count_source_select = writedata[source_bit];
        end
        count_off: count_next = writedata[15:0];
        period_off: period_value_next = writedata[15:0];
        irq_off: begin
          if (writedata[flag_bit]) flag_next = 1'b0;
          ien_next = writedata[enable_bit];
          prio_next = writedata[prio_lo_bit +: 3];
        end
        default: ;
      endcase
    end
    // Hardware set wins over a software clear.
    if (match_reg | gate_fall) flag_next = 1'b1;
    irq_next = flag_next & ien_next;
  end

  // Bus answer: one wait cycle, then acknowledge for one cycle; read data holds until the next read.
  // Waitrequest is kept in its own flop so that the port needs no inverter.
  always_comb begin
    rdata_next = rdata_reg;
    ack_next = (read | write) & ~ack_reg;
    wait_next = ~ack_next;
    // Read mux.
    if (read & ~ack_reg) begin
      case (address)
        ctrl_off: rdata_next = {16'h0000, ctl_reg.timer_run, 1'b0, ctl_reg.idle_stop,
                                6'h00, ctl_reg.gated_accumulate, ctl_reg.clock_divide_select,
                                1'b0, ctl_reg.ext_clock_resync, ctl_reg.count_source_select,
                                1'b0};
        count_off: rdata_next = {16'h0000, count_reg};
        period_off: rdata_next = {16'h0000, period_value_reg};
        irq_off: rdata_next = {25'h0000000, prio_reg, 2'h0, ien_reg, flag_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // Register the counter, control, period and interrupt state.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_reg <= tick_control_rst;
      count_reg <= count_rst;
      period_value_reg <= period_rst;
      flag_reg <= 1'b0;
      ien_reg <= 1'b0;
      prio_reg <= 3'h0;
      irq_reg <= 1'b0;
      match_reg <= 1'b0;
    end else begin
      ctl_reg <= ctl_next;
      count_reg <= count_next;
      period_value_reg <= period_value_next;
      flag_reg <= flag_next;
      ien_reg <= ien_next;
      prio_reg <= prio_next;
      irq_reg <= irq_next;
      match_reg <= match_next;
    end
  end

  // Register the bus answer; waitrequest rests high out of reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= 32'h00000000;
      ack_reg <= 1'b0;
      wait_reg <= 1'b1;
    end else begin
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      wait_reg <= wait_next;
    end
  end

  // Every output comes straight from its flop.
  assign waitrequest = wait_reg;
  assign readdata = rdata_reg;
  assign tick_irq = irq_reg;
  assign tick_irq_priority = prio_reg;

endmodule : interval_timer

// File: design/interval_timer_pkg.sv
// Constants, register map and field layout for the 16-bit interval timer.
// Assumes a 32-bit Avalon-MM slave port with word addressing by byte offset.
// Function
// - The block holds one 16-bit up-counter usable as interval timer or clock time base.
// - It counts as a timer on the internal clock, a synchronised counter or an unsynchronised counter.
// - The interrupt flag is raised on period match and, in gated mode, on the gate falling edge.
// - A two-bit prescale field in the control register selects the count clock divider.
// - Counting continues while the processor idles or sleeps unless stop-in-idle is set.
// - Counting runs only while the run bit is one.
// - With gating enabled the count advances only while the gate input is high.
// - Prescale codes 00, 01, 10, 11 divide by 1, 8, 64 and 256.
// - Source bit one counts external rising edges, zero counts the internal clock.
// - The gating bit acts only with the internal clock selected.
// - The resync bit acts only with the external clock selected.
package interval_timer_pkg;

  // Byte offsets of the registers.
  localparam logic [3:0] ctrl_off = 4'h0;
  localparam logic [3:0] count_off = 4'h4;
  localparam logic [3:0] period_off = 4'h8;
  localparam logic [3:0] irq_off = 4'hc;

  // Control register bit positions.
  localparam int run_bit = 15;
  localparam int idle_stop_bit = 13;
  localparam int gate_bit = 6;
  localparam int div_lo_bit = 4;
  localparam int resync_bit = 2;
  localparam int source_bit = 1;

  // Interrupt register layout: flag, enable, priority.
  localparam int flag_bit = 0;
  localparam int enable_bit = 1;
  localparam int prio_lo_bit = 4;

  // Reset values.
  localparam logic [15:0] count_rst = 16'h0000;
  localparam logic [15:0] period_rst = 16'hffff;

  // Prescaler terminal counts, one less than the ratio.
  localparam logic [7:0] div1_max = 8'h00;
  localparam logic [7:0] div8_max = 8'h07;
  localparam logic [7:0] div64_max = 8'h3f;
  localparam logic [7:0] div256_max = 8'hff;

  // Configuration as one carrier.
  typedef struct packed {
    logic timer_run;
    logic idle_stop;
    logic gated_accumulate;
    logic [1:0] clock_divide_select;
    logic ext_clock_resync;
    logic count_source_select;
  } tick_control_s;

  localparam tick_control_s tick_control_rst = '0;

endpackage : interval_timer_pkg

// File: design/tick_prescaler.sv
// Prescaler that turns raw count ticks into divided one-cycle ticks.
// Assumes the raw tick is a per-cycle enable on clk; each high cycle counts once.
`timescale 1ns/10ps
module tick_prescaler
  import interval_timer_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control.
  input wire logic clear,
  input wire logic [1:0] divide_sel,
  input wire logic raw_tick,
  // Divided tick.
  output logic div_tick
);

  logic [7:0] pre_reg;
  logic [7:0] pre_next;
  logic [7:0] max_cnt;
  logic div_next;
  logic div_reg;

  // Pick the terminal count for the selected ratio.
  always_comb begin
    case (divide_sel)
      2'h0: max_cnt = div1_max;
      2'h1: max_cnt = div8_max;
      2'h2: max_cnt = div64_max;
      default: max_cnt = div256_max;
    endcase
  end

  // Count raw ticks and emit one tick per full ratio.
  always_comb begin
    pre_next = pre_reg;
    div_next = 1'b0;
    if (clear) begin
      pre_next = 8'h00;
    end else if (raw_tick) begin
      if (pre_reg >= max_cnt) begin
        pre_next = 8'h00;
        div_next = 1'b1;
      end else begin
        pre_next = pre_reg + 8'h01;
      end
    end
  end

  // Register prescaler state.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_reg <= 8'h00;
      div_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      div_reg <= div_next;
    end
  end

  assign div_tick = div_reg;

endmodule : tick_prescaler

// File: testbench/interval_timer_monitor.sv
// Port checker for the interval timer.
// Assumes a bind onto the timer top.
`timescale 1ns/10ps
module interval_timer_monitor
  import interval_timer_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Bus and interrupt.
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic tick_irq,
  input wire logic [2:0] tick_irq_priority
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic wr_irq, en_reg, en_next;
  logic [2:0] pr_reg, pr_next;
  // Shadows enable and priority from accepted interrupt register writes.
  always_comb begin
    wr_irq = write && !waitrequest && address == irq_off;
    en_next = wr_irq ? writedata[enable_bit] : en_reg;
    pr_next = wr_irq ? writedata[prio_lo_bit +: 3] : pr_reg;
  end
  // Registers the shadow copies.
  always_ff @(posedge clk) begin
    en_reg <= rst_n && en_next;
    pr_reg <= rst_n ? pr_next : 3'h0;
  end
  property p_wait; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait");
  property p_ack; !waitrequest |=> waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("answer too long");
  property p_idle; !(read || write) |=> waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_high; read && !waitrequest |-> readdata[31:16] == 16'h0; endproperty
  a_high: assert property (p_high) else $error("upper read bits set");
  property p_hole; read && !waitrequest && address[1:0] != 2'h0 |-> readdata == 0; endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  property p_pr; wr_irq |-> ##[1:2] tick_irq_priority == pr_reg; endproperty
  a_pr: assert property (p_pr) else $error("priority not copied");
  property p_off; wr_irq && !writedata[enable_bit] |-> ##[1:2] !tick_irq; endproperty
  a_off: assert property (p_off) else $error("interrupt stays with enable off");
  property p_en; $rose(tick_irq) |-> en_reg || en_next; endproperty
  a_en: assert property (p_en) else $error("interrupt without enable");
  // Main scenarios seen.
  c_irq: cover property ($rose(tick_irq));
  c_hole: cover property (read && !waitrequest && address[1:0] != 2'h0);
  c_off: cover property (wr_irq && !writedata[enable_bit]);
endmodule : interval_timer_monitor

// File: testbench/pin_driver.sv
// Far-side pin model: external count clock and gate.
// Assumes its tasks are called just after a rising clk edge.
`timescale 1ns/10ps
module pin_driver (
  // Clock.
  input wire logic clk,
  // Pins toward the timer.
  output logic ext_count_input,
  output logic ext_gate_input
);
  // Both pins rest low until a scenario moves them.
  initial begin
    ext_count_input = 1'b0;
    ext_gate_input = 1'b0;
  end
  // Sends n rising edges, each level held for hold clocks.
  task automatic pulse(input int n, input int hold);
    for (int i = 0; i < 2 * n; i++) begin
      ext_count_input <= !ext_count_input;
      repeat (hold) @(posedge clk);
    end
  endtask : pulse
  // Moves the gate pin and lets one edge pass.
  task automatic gate(input logic level);
    ext_gate_input <= level;
    @(posedge clk);
  endtask : gate
endmodule : pin_driver

// File: testbench/interval_timer_bench.sv
// Testbench for the interval timer, one task per scenario.
// Assumes the pin model and the port checker are compiled first.
`timescale 1ns/10ps
module interval_timer_bench
  import interval_timer_pkg::*;
();
  localparam logic [31:0] run_word = 32'h8000;
  logic clk, rst_n, read, write, waitrequest, cpu_idle, tick_irq;
  logic ext_count_input, ext_gate_input;
  logic [3:0] address;
  logic [31:0] writedata, readdata, q;
  logic [2:0] tick_irq_priority;
  int failures, compares;
  // Design and far-side pin model.
  interval_timer u_interval_timer (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .ext_count_input(ext_count_input), .ext_gate_input(ext_gate_input), .cpu_idle(cpu_idle),
    .tick_irq(tick_irq), .tick_irq_priority(tick_irq_priority));
  pin_driver u_pin_driver (.clk(clk), .ext_count_input(ext_count_input),
    .ext_gate_input(ext_gate_input));
  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One bus transfer, held until waitrequest is sampled low; read data lands in q.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
    if (n >= 40) check("bus answer", 32'h0, 32'h1);
    if (n >= 40) test_done();
  endtask : bus
  // Waits a bounded time for the interrupt line.
  task automatic wait_irq();
    int n = 0;
    while (tick_irq !== 1'b1 && n < 600) begin
      @(posedge clk);
      n++;
    end
    check("interrupt line", 32'h1, 32'(tick_irq));
    if (n >= 600) test_done();
  endtask : wait_irq
  // Reset values and an unmapped read.
  task automatic t_reset();
    bus(0, ctrl_off, 0);
    check("control", 32'h0, q);
    bus(0, period_off, 0);
    check("period", 32'h0000ffff, q);
    bus(0, 4'h6, 0);
    check("unmapped", 32'h0, q);
    $display("t_reset done");
  endtask : t_reset
  // Internal 1:1 counting in idle, then a stop.
  task automatic t_count();
    logic [31:0] a;
    cpu_idle <= 1'b1;
    bus(1, ctrl_off, run_word);
    bus(0, count_off, 0);
    a = q;
    bus(0, count_off, 0);
    check("count step", 32'h3, q - a);
    bus(1, ctrl_off, 0);
    bus(0, count_off, 0);
    a = q;
    bus(0, count_off, 0);
    check("stopped count", a, q);
    bus(1, ctrl_off, run_word | (32'h1 << idle_stop_bit));
    bus(0, count_off, 0);
    a = q;
    bus(0, count_off, 0);
    check("idle stopped count", a, q);
    cpu_idle <= 1'b0;
    repeat (2) @(posedge clk);
    bus(0, count_off, 0);
    a = q;
    bus(0, count_off, 0);
    check("awake count step", 32'h3, q - a);
    bus(1, ctrl_off, 0);
    $display("t_count done");
  endtask : t_count
  // Prescale codes 01, 10 and 11, each for four divided ticks.
  task automatic t_presc();
    int r;
    for (int c = 1; c < 4; c++) begin
      r = (c == 3) ? 256 : 1 << (3 * c);
      bus(1, count_off, 0);
      bus(1, ctrl_off, run_word | (c << div_lo_bit));
      repeat (4 * r) @(posedge clk);
      bus(1, ctrl_off, 0);
      bus(0, count_off, 0);
      check("prescaled count", 32'h1, 32'(q >= 3 && q <= 5));
    end
    $display("t_presc done");
  endtask : t_presc
  // External edges, both resync settings, gating bit set and ignored.
  task automatic t_ext();
    for (int s = 0; s < 2; s++) begin
      bus(1, count_off, 0);
      bus(1, ctrl_off, run_word | 32'h42 | (s << resync_bit));
      u_pin_driver.pulse(10, 3 + s);
      repeat (8) @(posedge clk);
      bus(1, ctrl_off, 0);
      bus(0, count_off, 0);
      check("external count", 32'd10, q);
    end
    $display("t_ext done");
  endtask : t_ext
  // Period match wraps the count and raises the interrupt.
  task automatic t_match();
    bus(1, period_off, 32'h4);
    bus(1, count_off, 0);
    bus(1, irq_off, 32'h13);
    bus(1, ctrl_off, run_word);
    wait_irq();
    check("priority", 32'h1, 32'(tick_irq_priority));
    bus(1, ctrl_off, 0);
    bus(0, count_off, 0);
    check("count bound", 32'h1, 32'(q <= 4));
    bus(1, irq_off, 32'h1);
    bus(0, irq_off, 0);
    check("flag cleared", 32'h0, q);
    bus(1, period_off, 32'hffff);
    $display("t_match done");
  endtask : t_match
  // Gated accumulation and the interrupt on the gate falling edge.
  task automatic t_gate();
    bus(1, count_off, 0);
    bus(1, irq_off, 32'h53);
    bus(1, ctrl_off, run_word | 32'h40);
    repeat (20) @(posedge clk);
    bus(0, count_off, 0);
    check("gate low count", 32'h0, q);
    u_pin_driver.gate(1'b1);
    repeat (20) @(posedge clk);
    u_pin_driver.gate(1'b0);
    wait_irq();
    check("priority", 32'h5, 32'(tick_irq_priority));
    bus(1, ctrl_off, 0);
    bus(0, count_off, 0);
    check("gated count", 32'h1, 32'(q >= 15 && q <= 25));
    bus(1, irq_off, 32'h53);
    bus(0, irq_off, 0);
    check("irq register", 32'h52, q);
    $display("t_gate done");
  endtask : t_gate
  // Clock source.
  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end
  // Reset, then the scenarios in turn.
  initial begin
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    cpu_idle = 1'b0;
    failures = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_count();
    t_presc();
    t_ext();
    t_match();
    t_gate();
    test_done();
  end
endmodule : interval_timer_bench
bind interval_timer interval_timer_monitor u_interval_timer_monitor (.clk(clk), .rst_n(rst_n),
  .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .tick_irq(tick_irq), .tick_irq_priority(tick_irq_priority));
